// File: core/list_ctl_status.sv
/*
 * List control and command/status register bank of an open host controller.
 * Holds the list enables, the control/bulk service ratio, the write-to-set
 * command bits and the scheduling overrun counter, and steers the scheduler.
 * Assumes a single 40 MHz clock, a synchronous register port from the host
 * bus logic and a scheduler that reports its events as one-cycle pulses.
 */
`timescale 1ns/100ps
`include "list_ctl_consts.svh"

// Operation
// - Control list served only while enable set.
// - Iso descriptor with iso disabled halts periodic.
// - Iso enable takes effect next frame.
// - Periodic list served only while enable set; enable frozen at frame start, so a mid-frame clear acts next frame.
// - Ratio field selects one to four controls.
// - Ratio compared with count before non-periodic service.
// - Control count survives frame boundaries.
// - Command writes set ones, ignore zeros.
// - Command/status bits read back normally.
// - Unfinished periodic list at frame end overruns.
// - Overrun increments counter and sets flag.
// - Counter starts zero, wraps, counts while flagged.
module list_ctl_status (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host register port.
    input wire list_ctl_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Scheduler side.
    input wire list_ctl_pkg::sched_evt_t evt,
    output list_ctl_pkg::sched_ctl_t ctl
);

    // Register state, frozen enables and decoded strobes.
    logic rst_sync1; // First reset synchroniser stage.
    logic rst_sync_n; // Released reset used by all logic after the synchroniser.
    logic [4:0] list_control; // Enables and service ratio.
    logic [3:0] cmd_bits; // Write-to-set command bits.
    logic [1:0] overrun_count; // Scheduling overrun counter.
    logic overrun_flag; // Scheduling overrun flag of the interrupt status.
    logic iso_frame_en; // Iso enable frozen at the frame start.
    logic periodic_frame_en; // Periodic enable frozen at the frame start.
    logic [2:0] ctl_served; // Non-empty control descriptors served.
    list_ctl_pkg::per_state_t per_state; // Periodic list progress.
    logic wr_control; // Write strike on the list control register.
    logic wr_command; // Write strike on the command/status register.
    logic overrun_now; // Frame ended with the periodic list unfinished.
    logic iso_halt_now; // Iso descriptor met while iso is disabled.

    // Releases the reset through two flip-flops. Only the second stage reads
    // the first, so the logic never sees a half-settled release, while the
    // assertion of reset still reaches every flip-flop at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_sync_n <= rst_sync1;
        end
    end

    // Decodes the register writes.
    // A write to any other offset matches neither strobe and is dropped.
    assign wr_control = reg_req.wr && (reg_req.addr == `LCS_OFS_LIST_CONTROL);
    assign wr_command = reg_req.wr && (reg_req.addr == `LCS_OFS_COMMAND_STATUS);

    // An iso descriptor halts the periodic list when iso is off this frame.
    assign iso_halt_now = evt.iso_desc_seen && (per_state == list_ctl_pkg::PER_RUNNING)
        && !iso_frame_en;

    // The frame ends while the periodic list is still being processed.
    assign overrun_now = evt.end_of_frame && (per_state == list_ctl_pkg::PER_RUNNING)
        && !evt.periodic_done && !iso_halt_now;

    // Holds the list control register; only the list fields are writable.
    // The upper bits are not stored at all and read back as zero.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            list_control <= `LCS_CONTROL_RESET;
        end else if (wr_control) begin
            list_control <= reg_req.wdata[4:0];
        end
    end

    // Command bits: ones written set, zeros leave alone, a set beats a clear.
    // The scheduler clears a bit once it has acted on it; a command written in
    // the same cycle survives, so the driver never loses a request.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmd_bits <= `LCS_CMD_RESET;
        end else begin
            cmd_bits <= (cmd_bits & ~evt.cmd_clear)
                | (wr_command ? reg_req.wdata[`LCS_CMD_MSB:`LCS_CMD_LSB] : 4'h0);
        end
    end

    // Counts overruns from zero, wrapping, regardless of the flag.
    // Wrapping from three to zero is intended: the driver watches the trend,
    // not the absolute number.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            overrun_count <= `LCS_OVR_CNT_RESET;
        end else if (overrun_now) begin
            overrun_count <= overrun_count + 2'h1;
        end
    end

    // Sets the overrun flag; a new overrun wins over a clear in the same cycle.
    // The clear comes from the interrupt status logic when the driver acknowledges.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            overrun_flag <= 1'b0;
        end else if (overrun_now) begin
            overrun_flag <= 1'b1;
        end else if (evt.overrun_flag_clear) begin
            overrun_flag <= 1'b0;
        end
    end

    // Freezes the iso and periodic enables at each frame start.
    // Freezing keeps a mid-frame change of either enable away from a list that
    // is already being served; it takes hold at the following frame start.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            iso_frame_en <= 1'b0;
            periodic_frame_en <= 1'b0;
        end else if (evt.frame_start) begin
            iso_frame_en <= list_control[`LCS_ISO_EN_BIT];
            periodic_frame_en <= list_control[`LCS_PERIODIC_EN_BIT];
        end
    end

    // Follows the periodic list through each frame.
    // Finished means the list is done for this frame, by any of its three ends.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            per_state <= list_ctl_pkg::PER_IDLE;
        end else begin
            unique case (per_state)
                list_ctl_pkg::PER_IDLE: begin
                    // Starts only when the periodic enable is seen set.
                    if (evt.frame_start && list_control[`LCS_PERIODIC_EN_BIT]) begin
                        per_state <= list_ctl_pkg::PER_RUNNING;
                    end
                end
                list_ctl_pkg::PER_RUNNING: begin
                    // Ends on completion, on an iso halt or at frame end.
                    if (evt.periodic_done || iso_halt_now || evt.end_of_frame) begin
                        per_state <= list_ctl_pkg::PER_FINISHED;
                    end
                end
                list_ctl_pkg::PER_FINISHED: begin
                    // Waits for the next frame and its enable.
                    if (evt.frame_start) begin
                        per_state <= list_control[`LCS_PERIODIC_EN_BIT]
                            ? list_ctl_pkg::PER_RUNNING : list_ctl_pkg::PER_IDLE;
                    end
                end
            endcase
        end
    end

    // Counts control descriptors; cleared when a bulk descriptor completes during bulk service.
    // Frame starts leave the count alone, so a partly used ratio carries over
    // into the next frame. The count saturates one above the ratio, which is
    // as far as the comparison with the ratio needs to look.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctl_served <= 3'h0;
        end else if (evt.bulk_desc_done && !ctl.serve_control) begin
            ctl_served <= 3'h0;
        end else if (evt.ctl_desc_done && ctl_served <= {1'b0, list_control[1:0]}) begin
            ctl_served <= ctl_served + 3'h1;
        end
    end

    // Drives the scheduler permissions and decisions from flip-flops.
    // The control enable is passed on live, since the scheduler samples it each
    // time it turns to the control list; the others are the frozen copies.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctl <= '0;
        end else begin
            ctl.control_go <= list_control[`LCS_CTL_EN_BIT];
            ctl.periodic_go <= periodic_frame_en;
            ctl.iso_go <= iso_frame_en;
            ctl.periodic_halt <= iso_halt_now;
            // Ratio 0..3 allows 1..4 control descriptors before bulk.
            ctl.serve_control <= (ctl_served <= {1'b0, list_control[1:0]});
            ctl.overrun_pulse <= overrun_now;
            ctl.overrun_flag <= overrun_flag;
            ctl.overrun_count <= overrun_count;
            ctl.cmd_bits <= cmd_bits;
        end
    end

    // Answers register reads one cycle after the read strobe.
    // Read data returns to zero between answers, and an unmapped offset is
    // answered with zero and a valid strobe.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (!reg_req.rd) begin
                reg_rdata <= 32'h00000000;
            end else if (reg_req.addr == `LCS_OFS_LIST_CONTROL) begin
                reg_rdata <= {27'h0, list_control};
            end else if (reg_req.addr == `LCS_OFS_COMMAND_STATUS) begin
                reg_rdata <= {14'h0, overrun_count, 12'h0, cmd_bits};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

endmodule

// File: core/list_ctl_consts.svh
/*
 * Offsets, field positions, reset values and widths of the list control and
 * command/status register bank.
 * Assumes inclusion by bare name from any design file that decodes registers.
 */
`ifndef LIST_CTL_CONSTS_SVH
`define LIST_CTL_CONSTS_SVH

// Register byte offsets on the host register port.
`define LCS_OFS_LIST_CONTROL 8'h04
`define LCS_OFS_COMMAND_STATUS 8'h08

// Fields of the list control register.
`define LCS_RATIO_LSB 0
`define LCS_RATIO_MSB 1
`define LCS_PERIODIC_EN_BIT 2
`define LCS_ISO_EN_BIT 3
`define LCS_CTL_EN_BIT 4
`define LCS_CONTROL_WMASK 32'h0000001f
`define LCS_CONTROL_RESET 5'h00

// Fields of the command/status register.
`define LCS_CMD_LSB 0
`define LCS_CMD_MSB 3
`define LCS_CMD_RESET 4'h0
`define LCS_OVR_CNT_LSB 16
`define LCS_OVR_CNT_MSB 17
`define LCS_OVR_CNT_RESET 2'h0

`endif

// File: core/list_ctl_pkg.sv
/*
 * Types shared by the list control and command/status register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package list_ctl_pkg;

    // Host register port request, one cycle wide.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Events reported by the list scheduler, each a one-cycle pulse.
    typedef struct packed {
        logic frame_start;
        logic end_of_frame;
        logic periodic_done;
        logic iso_desc_seen;
        logic ctl_desc_done;
        logic bulk_desc_done;
        logic [3:0] cmd_clear;
        logic overrun_flag_clear;
    } sched_evt_t;

    // Permissions and decisions handed to the list scheduler.
    typedef struct packed {
        logic control_go;
        logic periodic_go;
        logic iso_go;
        logic periodic_halt;
        logic serve_control;
        logic overrun_pulse;
        logic overrun_flag;
        logic [1:0] overrun_count;
        logic [3:0] cmd_bits;
    } sched_ctl_t;

    // Tracking state of the periodic list within a frame.
    typedef enum logic [1:0] {
        PER_IDLE,
        PER_RUNNING,
        PER_FINISHED
    } per_state_t;

endpackage

// File: verif/list_ctl_properties.sv
/* Port assertions of the list control bank.
   Assumes binding to list_ctl_status. */
`timescale 1ns/100ps
module list_ctl_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire list_ctl_pkg::reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Scheduler side.
    input wire list_ctl_pkg::sched_evt_t evt,
    input wire list_ctl_pkg::sched_ctl_t ctl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Writes to each register.
    logic wr4;
    logic wr8;
    assign wr4 = reg_req.wr && reg_req.addr == 8'h04;
    assign wr8 = reg_req.wr && reg_req.addr == 8'h08;
    a_read_answered: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered");
    a_idle_read_zero: assert property (!$past(reg_req.rd) |-> !reg_rvalid && reg_rdata == 32'h0)
        else $error("read data without read");
    a_cmd_write_sets: assert property (wr8 |-> ##2
        (ctl.cmd_bits & $past(reg_req.wdata[3:0], 2)) == $past(reg_req.wdata[3:0], 2))
        else $error("command bit not set");
    a_control_go_follows: assert property (wr4 |-> ##2 ctl.control_go == $past(reg_req.wdata[4], 2))
        else $error("control enable not followed");
    a_overrun_counts: assert property (ctl.overrun_pulse |=> ctl.overrun_flag &&
        ctl.overrun_count == 2'($past(ctl.overrun_count) + 2'h1))
        else $error("overrun not counted");
    a_count_only_overrun: assert property ($changed(ctl.overrun_count) |-> $past(ctl.overrun_pulse))
        else $error("counter moved without overrun");
    a_overrun_cause: assert property (ctl.overrun_pulse |-> $past(evt.end_of_frame) &&
        !$past(evt.periodic_done))
        else $error("overrun without frame end");
    a_go_frame_start: assert property ($changed({ctl.iso_go, ctl.periodic_go}) |->
        $past(evt.frame_start) || $past(evt.frame_start, 2))
        else $error("enable changed within frame");
    a_halt_iso_off: assert property (ctl.periodic_halt |-> !ctl.iso_go &&
        ($past(evt.iso_desc_seen) || $past(evt.iso_desc_seen, 2)))
        else $error("bad periodic halt");
    a_bulk_switch: assert property ($fell(ctl.serve_control) |->
        $past(evt.ctl_desc_done) || $past(evt.ctl_desc_done, 2))
        else $error("bulk switch without control service");
    c_overrun: cover property (ctl.overrun_pulse);
    c_halt: cover property (ctl.periodic_halt);
    c_bulk: cover property ($fell(ctl.serve_control));
endmodule
bind list_ctl_status list_ctl_checker u_chk (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .evt(evt), .ctl(ctl));

// File: verif/testbench.sv
/* Self-checking bench of the list control bank.
   Assumes the design package and the bound checker. */
`timescale 1ns/100ps
module testbench;
    // Ratio code beside control descriptors served before bulk.
    typedef struct packed {logic [1:0] ratio; logic [31:0] served;} row_t;
    row_t rows [4] = '{'{2'h0, 32'h1}, '{2'h1, 32'h2}, '{2'h2, 32'h3}, '{2'h3, 32'h4}};
    localparam logic [10:0] ev_fs = 11'h400;
    localparam logic [10:0] ev_eof = 11'h200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    list_ctl_pkg::reg_req_t req = '0;
    list_ctl_pkg::sched_evt_t ev = '0;
    logic [31:0] rdata;
    logic rvalid;
    list_ctl_pkg::sched_ctl_t ctl;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int halt_count = 0;
    int ovr_count = 0;
    int base = 0;
    logic [31:0] v;
    int n;
    always #12.5 clk = ~clk;
    list_ctl_status dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .evt(ev), .ctl(ctl));
    // Counts cycles against a ceiling and counts halt and overrun pulses.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ctl.periodic_halt === 1'b1) begin
            halt_count <= halt_count + 1;
        end
        if (ctl.overrun_pulse === 1'b1) begin
            ovr_count <= ovr_count + 1;
        end
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        req = '{1'b0, 1'b1, a, 32'h0};
        @(negedge clk);
        req = '0;
        v = rdata;
        check("rvalid", 32'(rvalid), 32'h1);
    endtask
    // One event pulse, then time for the outputs to settle.
    task automatic pulse(input logic [10:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = '0;
        repeat (2) @(negedge clk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h04);
        check("control reset", v, 32'h0);
        rd(8'h0c);
        check("unmapped", v, 32'h0);
        // Each ratio code, with a frame start inside the count.
        foreach (rows[i]) begin
            wr(8'h04, {27'h0, 3'h4, rows[i].ratio});
            n = 0;
            while (ctl.serve_control === 1'b1 && n < 8) begin
                pulse(11'h040);
                n++;
                if (n == 1) begin
                    pulse(ev_fs);
                end
            end
            check("served", 32'(n), rows[i].served);
            check("control_go", 32'(ctl.control_go), 32'h1);
            pulse(11'h020);
            check("after bulk", 32'(ctl.serve_control), 32'h1);
        end
        wr(8'h04, 32'h0);
        repeat (2) @(negedge clk);
        check("control off", 32'(ctl.control_go), 32'h0);
        wr(8'h08, 32'h1);
        wr(8'h08, 32'h2);
        wr(8'h08, 32'hfffffff0);
        rd(8'h08);
        check("command set", v, 32'h3);
        check("command bits", 32'(ctl.cmd_bits), 32'h3);
        wr(8'h04, 32'h4);
        repeat (5) begin
            pulse(ev_fs);
            pulse(ev_eof);
        end
        rd(8'h08);
        check("overrun count", v, 32'h00010003);
        check("overrun flag", 32'(ctl.overrun_flag), 32'h1);
        check("overrun pulses", 32'(ovr_count), 32'h5);
        pulse(11'h001);
        pulse(ev_fs);
        pulse(11'h100);
        pulse(ev_eof);
        wr(8'h04, 32'h0);
        pulse(ev_fs);
        check("periodic off", 32'(ctl.periodic_go), 32'h0);
        pulse(ev_eof);
        rd(8'h08);
        check("no overrun", v, 32'h00010003);
        check("flag clear", 32'(ctl.overrun_flag), 32'h0);
        check("no more pulses", 32'(ovr_count), 32'h5);
        wr(8'h04, 32'h4);
        pulse(ev_fs);
        wr(8'h04, 32'hc);
        base = halt_count;
        pulse(11'h080);
        check("halt", 32'(halt_count - base), 32'h1);
        check("iso same frame", 32'(ctl.iso_go), 32'h0);
        pulse(ev_fs);
        base = halt_count;
        pulse(11'h080);
        check("no halt", 32'(halt_count - base), 32'h0);
        check("iso next frame", 32'(ctl.iso_go), 32'h1);
        check("periodic on", 32'(ctl.periodic_go), 32'h1);
        // A reset in mid-run puts every register back to zero.
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("counter reset", 32'(ctl.overrun_count), 32'h0);
        rd(8'h08);
        check("status reset", v, 32'h0);
        // The driver restores the ratio and re-enables control.
        wr(8'h04, 32'h11);
        rd(8'h04);
        check("ratio restored", v, 32'h11);
        // A software set beats a hardware clear of the same bit.
        @(negedge clk);
        req = '{1'b1, 1'b0, 8'h08, 32'h4};
        ev = 11'h008;
        @(negedge clk);
        req = '0;
        ev = '0;
        rd(8'h08);
        check("set beats clear", v, 32'h4);
        pulse(11'h008);
        rd(8'h08);
        check("hardware clear", v, 32'h0);
        results();
    end
endmodule
